// >>> hw/tpb_pkg.sv
// Package for the two-phase peripheral bus slave interface
package tpb_pkg;
    localparam int unsigned ADDR_W      = 16;
    localparam int unsigned LOCAL_ADDR_W = 3;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned REGS_PER_SEL = 8;
    localparam int unsigned NUM_SEL     = 2;
    localparam logic [7:0]  REG_RESET   = 8'h00;
    // Phase sequencer states, each held until the next phase strobe
    typedef enum logic [0:0] {
        TPB_PH_ONE,
        TPB_PH_TWO
    } tpb_phase_type;
endpackage

// >>> hw/tpb_slave.sv
// Peripheral-side slave of the two-phase internal bus with a small register bank
// What this block does
// - In phase one data lines are driven by master on writes, peripheral on reads.
// - Peripheral captures address, direction, valid_n and select_n at the rise of phase one.
// - Data is captured at phase two: by master on reads, into register on writes.
// - Peripheral uses low three address bits with one select_n for up to eight registers.
// - More than eight registers need extra select_n lines, each for eight registers.
// - On reads the peripheral drives register contents once its decode settles.
// - Timing applies to register peripherals only, not RAM, program memory or USB.
module tpb_slave #(
    parameter int unsigned NUM_SEL = tpb_pkg::NUM_SEL
) (
    // Clock and reset
    input  wire logic                                   clk_in,
    input  wire logic                                   resetn_in,
    // Bus phase strobes, one-cycle pulses at the rise of each phase
    input  wire logic                                   phase_one_in,
    input  wire logic                                   phase_two_in,
    // Bus request side
    input  wire logic [tpb_pkg::LOCAL_ADDR_W-1:0]       addr_bus_in,
    input  wire logic                                   read_not_write_in,
    input  wire logic                                   valid_n_in,
    input  wire logic [NUM_SEL-1:0]                     select_n_in,
    // Shared data lines as three signals
    input  wire logic [tpb_pkg::DATA_W-1:0]             data_lines_in,
    output logic      [tpb_pkg::DATA_W-1:0]             data_lines_out,
    output logic                                        data_lines_oe_out,
    // Register contents seen by the peripheral core
    output logic      [NUM_SEL*tpb_pkg::REGS_PER_SEL*tpb_pkg::DATA_W-1:0] regs_out,
    // One-cycle pulse per register written
    output logic      [NUM_SEL*tpb_pkg::REGS_PER_SEL-1:0] reg_wr_out
);
    localparam int unsigned NREG  = NUM_SEL * tpb_pkg::REGS_PER_SEL;
    localparam int unsigned IDX_W = (NREG > 1) ? $clog2(NREG) : 1;

    // Captured request fields and bus phase
    tpb_pkg::tpb_phase_type           phase_q, phase_d;
    logic [tpb_pkg::LOCAL_ADDR_W-1:0] addr_q, addr_d;
    logic                             rnw_q, rnw_d;
    logic                             valid_n_q, valid_n_d;
    logic [NUM_SEL-1:0]               sel_n_q, sel_n_d;
    // Read driver
    logic [tpb_pkg::DATA_W-1:0]       rdata_q, rdata_d;
    logic                             oe_q, oe_d;
    // Register bank, the only thing behind this timing
    logic [tpb_pkg::DATA_W-1:0]       bank_q [NREG];
    logic [tpb_pkg::DATA_W-1:0]       bank_d [NREG];
    // Write strobes to the peripheral core
    logic [NREG-1:0]                  wr_q, wr_d;
    // Decode results
    logic [NREG-1:0]                  reg_hit;
    logic                             any_hit;
    logic [IDX_W-1:0]                 hit_idx;
    logic                             wr_take;

    // Register select; highest group wins so only one register is hit
    always_comb
    begin
        reg_hit = '0;
        hit_idx = '0;
        any_hit = 1'h0;
        for (int g = 0; g < NUM_SEL; g++)
        begin
            if (!sel_n_q[g] && !valid_n_q && (phase_q == tpb_pkg::TPB_PH_TWO))
            begin
                hit_idx = IDX_W'(g * tpb_pkg::REGS_PER_SEL) + IDX_W'(addr_q);
                any_hit = 1'h1;
            end
        end
        reg_hit[hit_idx] = any_hit;  // One-hot even with stray selects
    end

    // Phase tracker: open at phase one, closed at phase two
    always_comb
    begin
        phase_d = phase_q;
        unique case (phase_q)
            tpb_pkg::TPB_PH_ONE:
            begin
                if (phase_one_in)
                begin
                    phase_d = tpb_pkg::TPB_PH_TWO;
                end
            end
            tpb_pkg::TPB_PH_TWO:
            begin
                if (phase_two_in)
                begin
                    phase_d = tpb_pkg::TPB_PH_ONE;
                end
            end
        endcase
    end

    // Phase tracker register
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            phase_q <= tpb_pkg::TPB_PH_ONE;
        end
        else
        begin
            phase_q <= phase_d;
        end
    end

    // Request capture on phase one; valid dropped at phase two
    always_comb
    begin
        addr_d    = addr_q;
        rnw_d     = rnw_q;
        valid_n_d = valid_n_q;
        sel_n_d   = sel_n_q;
        if (phase_one_in)
        begin
            addr_d    = addr_bus_in;
            rnw_d     = read_not_write_in;
            valid_n_d = valid_n_in;
            sel_n_d   = select_n_in;
        end
        if (phase_two_in)
        begin
            valid_n_d = 1'h1;              // Access never repeats
        end
    end

    // Request capture registers
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            addr_q    <= '0;
            rnw_q     <= 1'h1;
            valid_n_q <= 1'h1;
            sel_n_q   <= '1;
        end
        else
        begin
            addr_q    <= addr_d;
            rnw_q     <= rnw_d;
            valid_n_q <= valid_n_d;
            sel_n_q   <= sel_n_d;
        end
    end

    // Read drive from the second cycle after capture; one cycle spent on decode
    always_comb
    begin
        rdata_d = rdata_q;
        oe_d    = any_hit && rnw_q && !phase_two_in;
        if (any_hit && rnw_q)
        begin
            rdata_d = bank_q[hit_idx];
        end
    end

    // Read driver registers
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            rdata_q <= tpb_pkg::REG_RESET;
            oe_q    <= 1'h0;
        end
        else
        begin
            rdata_q <= rdata_d;
            oe_q    <= oe_d;
        end
    end

    // Write data taken at phase two; master drives it from phase one
    assign wr_take = phase_two_in && any_hit && !rnw_q;

    // Register bank next value
    always_comb
    begin
        bank_d = bank_q;
        if (wr_take)
        begin
            bank_d[hit_idx] = data_lines_in;
        end
    end

    // Register bank storage
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                bank_q[i] <= tpb_pkg::REG_RESET;
            end
        end
        else
        begin
            bank_q <= bank_d;
        end
    end

    // Write strobe, one cycle per register written
    always_comb
    begin
        wr_d = '0;
        if (wr_take)
        begin
            wr_d = reg_hit;
        end
    end

    // Write strobe register
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            wr_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
        end
    end

    // Outputs; drive gated by the stored enable only
    assign data_lines_out    = rdata_q;
    assign data_lines_oe_out = oe_q;
    assign reg_wr_out        = wr_q;
    for (genvar k = 0; k < NREG; k++)
    begin : g_regs
        assign regs_out[k*tpb_pkg::DATA_W +: tpb_pkg::DATA_W] = bank_q[k];
    end
endmodule

// >>> test/tpb_slave_assertions.sv
// Port timing checks for the bus slave
module tpb_slave_chk #(parameter int unsigned NUM_SEL = 2) (
    // Clock, reset and bus side
    input wire logic                  clk_in, resetn_in, phase_one_in, phase_two_in,
    input wire logic [2:0]            addr_bus_in,
    input wire logic                  read_not_write_in, valid_n_in, data_lines_oe_out,
    input wire logic [NUM_SEL-1:0]    select_n_in,
    input wire logic [7:0]            data_lines_in, data_lines_out,
    // Register side
    input wire logic [NUM_SEL*64-1:0] regs_out,
    input wire logic [NUM_SEL*8-1:0]  reg_wr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    logic hit, wr_q;
    // Write hit held from phase one to phase two
    assign hit = !valid_n_in && !(&select_n_in);
    always_ff @(posedge clk_in)
        wr_q <= (!resetn_in || phase_two_in) ? 1'b0 : (phase_one_in ? hit && !read_not_write_in : wr_q);
    property p_rd; phase_one_in && hit && read_not_write_in |-> ##2 data_lines_oe_out; endproperty
    a_rd: assert property (p_rd) else $error("read not driven");
    property p_nd; phase_one_in && !(hit && read_not_write_in) |-> ##2 !data_lines_oe_out; endproperty
    a_nd: assert property (p_nd) else $error("drive without read");
    property p_st; data_lines_oe_out && !phase_two_in |=> data_lines_oe_out; endproperty
    a_st: assert property (p_st) else $error("drive dropped early");
    property p_dr; phase_two_in |=> !data_lines_oe_out; endproperty
    a_dr: assert property (p_dr) else $error("drive held after phase two");
    property p_wr; phase_two_in && wr_q |=> $onehot(reg_wr_out); endproperty
    a_wr: assert property (p_wr) else $error("write lost");
    property p_nw; !(phase_two_in && wr_q) |=> reg_wr_out == '0; endproperty
    a_nw: assert property (p_nw) else $error("stray write");
    property p_rs; reg_wr_out == '0 |-> $stable(regs_out); endproperty
    a_rs: assert property (p_rs) else $error("register changed");
endmodule

bind tpb_slave tpb_slave_chk #(.NUM_SEL(NUM_SEL)) tpb_slave_chk_i (.*);

// >>> test/tpb_master_model.sv
// Bus master model issuing phased accesses
module tpb_master_model (
    input  wire logic       clk_in, oe_in,
    input  wire logic [7:0] dout_in,
    output logic            p1_out = 0, p2_out = 0, rnw_out = 1, valid_n_out = 1,
    output logic [2:0]      addr_out = 0,
    output logic [1:0]      sel_n_out = 3,
    output logic [7:0]      bus_out, rd_out = 0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       wdrv = 0;
    logic [7:0] wd = 0, last = 0;
    // Released bus toggles so no stale value can pass
    assign bus_out = (oe_in === 1'b1) ? dout_in : (wdrv ? wd : ~last);
    always @(posedge clk_in) last <= bus_out;
    task automatic access(input logic r, v, input logic [1:0] s, input logic [2:0] a, input logic [7:0] d, int gap);
        {p1_out, rnw_out, valid_n_out, sel_n_out, addr_out} <= {1'b1, r, v, s, a};
        @(posedge clk_in) {p1_out, wdrv, wd} <= {1'b0, !r, d};
        repeat (gap) @(posedge clk_in);
        p2_out <= 1;
        @(posedge clk_in) rd_out <= bus_out;
        {p2_out, wdrv, valid_n_out, sel_n_out, addr_out} <= {1'h0, 1'h0, 1'h1, 2'h3, 3'($urandom)};
    endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for the bus slave
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_in = 0, resetn_in = 0, p1, p2, rnw, vn, oe, oe_q = 0, r, v;
    logic [1:0]   sn, s;
    logic [2:0]   ad;
    logic [3:0]   k;
    logic [7:0]   bus, dout, rd, d, e [16] = '{default: 8'h00};
    logic [127:0] regs;
    logic [15:0]  wr, got, n, q [$];
    int           err_total = 0, samples_checked = 0, cyc = 0;
    tpb_master_model m (.clk_in, .oe_in(oe), .dout_in(dout), .p1_out(p1), .p2_out(p2), .rnw_out(rnw),
        .valid_n_out(vn), .addr_out(ad), .sel_n_out(sn), .bus_out(bus), .rd_out(rd));
    tpb_slave tpb_slave_i (.clk_in, .resetn_in, .phase_one_in(p1), .phase_two_in(p2), .addr_bus_in(ad),
        .read_not_write_in(rnw), .valid_n_in(vn), .select_n_in(sn), .data_lines_in(bus),
        .data_lines_out(dout), .data_lines_oe_out(oe), .regs_out(regs), .reg_wr_out(wr));
    initial forever #2 clk_in = ~clk_in;
    task automatic summarize;
        $display("Checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watcher pops a note per write pulse or finished read, plus the hang limit
    always @(posedge clk_in)
    begin
        cyc++;
        oe_q <= oe;
        if (resetn_in && (wr !== 16'h0000 || (oe_q && !oe)))
        begin
            got = {8'hFF, rd};
            for (int j = 0; j < 16; j++) if (wr[j]) got = {4'h0, 4'(j), regs[8*j +: 8]};
            n = q.pop_front();
            samples_checked++;
            if (got !== n) begin err_total++; $display("Error t=%0t exp=%h got=%h", $time, n, got); end
        end
        if (cyc == 5000) begin err_total++; summarize(); end
    end
    // Random reads and writes over both groups, some refused or double-selected
    initial
    begin
        void'($urandom(79));
        repeat (4) @(posedge clk_in);
        resetn_in <= 1;
        for (int i = 0; i < 90; i++)
        begin
            @(posedge clk_in);
            {r, k, d} = 13'($urandom);
            v = $urandom_range(7) == 0;
            s = k[3] ? 2'b01 : 2'b10;
            if ($urandom_range(5) == 0) s = k[3] ? 2'b00 : 2'b11; // Highest group wins or none
            if (!v && s != 2'b11) q.push_back(r ? {8'hFF, e[k]} : {4'h0, k, d});
            if (!v && s != 2'b11 && !r) e[k] = d;
            m.access(r, v, s, k[2:0], d, $urandom_range(3) + 1);
        end
        repeat (4) @(posedge clk_in);
        if (q.size() != 0)
        begin
            err_total++;
            $display("Error t=%0t exp=%h got=%h", $time, 0, q.size());
        end
        summarize();
    end
endmodule
